// *** rtl/identify_pkg.sv ***
package identify_pkg;

  // apb byte offsets of the register window
  localparam logic [7:0] OFF_DATA        = 8'h00;
  localparam logic [7:0] OFF_ERROR       = 8'h04;
  localparam logic [7:0] OFF_STATUS      = 8'h08;
  localparam logic [7:0] OFF_COMMAND     = 8'h0C;
  localparam logic [7:0] OFF_DRIVE_HEAD  = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h18;

  // command code that asks for the configuration block
  localparam logic [7:0] CMD_IDENTIFY    = 8'hEC;
  // device-select bit position inside drive_select_head
  localparam int         DEV_BIT         = 4;

  // sector geometry of the transfer
  localparam int         SECTOR_WORDS    = 256;
  localparam logic [7:0] LAST_WORD       = 8'hFF;

  // fixed contents of the configuration block
  localparam logic [15:0] W0_COMPLETE    = 16'h045A;
  localparam logic [15:0] W0_INCOMPLETE  = 16'h045E;
  localparam logic [15:0] W2_SPIN_PART   = 16'h37C8;
  localparam logic [15:0] W2_SPIN_FULL   = 16'h738C;
  localparam logic [15:0] W2_NOSPIN_PART = 16'h8C73;
  localparam logic [15:0] W2_NOSPIN_FULL = 16'hC837;
  localparam logic [15:0] W6_SECTORS     = 16'h003F;
  localparam logic [15:0] W20_CTRL_TYPE  = 16'h0003;
  localparam logic [15:0] W22_ECC_BYTES  = 16'h0038;
  localparam logic [15:0] W47_MULTIPLE   = 16'h8010;
  localparam logic [15:0] W48_SECURITY   = 16'h4000;
  localparam logic [15:0] WORD_ZERO      = 16'h0000;

  // reset values
  localparam logic [7:0]  DRIVE_HEAD_RST = 8'hA0;
  localparam logic [2:0]  IRQ_RST        = 3'h0;

  // interrupt event bit positions
  localparam int EV_DRQ   = 0;
  localparam int EV_DONE  = 1;
  localparam int EV_ABORT = 2;

  // task-file status byte
  typedef struct packed {
    logic busy;
    logic ready;
    logic fault;
    logic seek_done;
    logic drq;
    logic corrected;
    logic index;
    logic err;
  } status_type;

  // task-file error byte
  typedef struct packed {
    logic crc;
    logic uncorrectable;
    logic rsvd5;
    logic id_missing;
    logic rsvd3;
    logic abort;
    logic track0_missing;
    logic mark_missing;
  } error_type;

  // command engine states
  typedef enum logic [1:0] {ST_IDLE, ST_PREPARE, ST_TRANSFER} state_type;

  localparam status_type STATUS_RST = 8'h50;
  localparam error_type  ERROR_RST  = 8'h00;

endpackage

// *** rtl/identify_device_responder.sv ***
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module identify_device_responder
  import identify_pkg::*;
#(
  parameter logic [15:0]  CYLINDERS      = 16'h3FFF,                 // default-translation cylinders
  parameter logic [7:0]   HEADS          = 8'h10,                    // default-translation heads
  parameter logic [15:0]  BUFFER_UNITS   = 16'h0100,                 // buffer size in 512-byte units
  parameter logic         SPINUP_NEEDED  = 1'b0,                     // spin-up feature command required
  parameter logic         INCOMPLETE     = 1'b0,                     // response marked incomplete
  parameter logic         DEVICE_NUM     = 1'b0,                     // device-select value answered
  parameter logic [159:0] SERIAL_TEXT    = "00000000000000000001",   // arbitrary serial text
  parameter logic [63:0]  FIRMWARE_TEXT  = "REV00001",               // arbitrary firmware text
  parameter logic [319:0] MODEL_TEXT     = {"GENERIC DISK", {28{8'h20}}} // arbitrary model text
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  state_type   state;          // command engine state
  status_type  status;         // status byte seen by the host
  error_type   error;          // error byte seen by the host
  logic [7:0]  drive_head;     // drive_select_head register
  logic [7:0]  word_index;     // next configuration word to hand out
  logic        cmd_ok;         // latched command is executable
  logic [2:0]  irq_status;     // sticky event bits
  logic [2:0]  irq_mask;       // interrupt enables
  logic [15:0] cur_word;       // word at the current index
  logic [31:0] next_prdata;    // read data for the pending access
  logic        mapped;         // address hits a register

  // apb handshake terms: an access completes when pready is sampled high
  logic wr_take;
  logic rd_take;
  logic cmd_write;
  logic data_pop;
  logic ev_drq;
  logic ev_done;
  logic ev_abort;
  assign wr_take   = psel & penable & pready & pwrite;
  assign rd_take   = psel & penable & pready & ~pwrite;
  assign cmd_write = wr_take & (paddr == OFF_COMMAND);
  assign data_pop  = rd_take & (paddr == OFF_DATA) & (state == ST_TRANSFER);
  assign ev_drq    = (state == ST_PREPARE) & cmd_ok;
  assign ev_done   = data_pop & (word_index == LAST_WORD);
  assign ev_abort  = (state == ST_PREPARE) & ~cmd_ok;

  // configuration word for a given index
  function automatic logic [15:0] config_word(input logic [7:0] idx);
    int i;
    logic [15:0] w;
    i = int'(idx);
    w = WORD_ZERO;
    if (i == 0) begin
      w = INCOMPLETE ? W0_INCOMPLETE : W0_COMPLETE;
    end else if (i == 1) begin
      w = CYLINDERS;
    end else if (i == 2) begin
      unique case ({SPINUP_NEEDED, INCOMPLETE})
        2'b11:   w = W2_SPIN_PART;
        2'b10:   w = W2_SPIN_FULL;
        2'b01:   w = W2_NOSPIN_PART;
        2'b00:   w = W2_NOSPIN_FULL;
      endcase
    end else if (i == 3) begin
      w = {8'h00, HEADS};
    end else if (i == 6) begin
      w = W6_SECTORS;
    end else if (i >= 10 && i <= 19) begin
      // serial text, first character in upper byte
      w = SERIAL_TEXT[159 - 16 * (i - 10) -: 16];
    end else if (i == 20) begin
      w = W20_CTRL_TYPE;
    end else if (i == 21) begin
      w = BUFFER_UNITS;
    end else if (i == 22) begin
      w = W22_ECC_BYTES;
    end else if (i >= 23 && i <= 26) begin
      w = FIRMWARE_TEXT[63 - 16 * (i - 23) -: 16];
    end else if (i >= 27 && i <= 46) begin
      w = MODEL_TEXT[319 - 16 * (i - 27) -: 16];
    end else if (i == 47) begin
      w = W47_MULTIPLE;
    end else if (i == 48) begin
      w = W48_SECURITY;
    end
    return w;
  endfunction

  // data port shows zero outside a transfer
  assign cur_word = (state == ST_TRANSFER) ? config_word(word_index) : WORD_ZERO;

  // read mux and address decode
  always_comb begin
    next_prdata = 32'h0000_0000;
    mapped      = 1'b1;
    unique case (paddr)
      OFF_DATA:       next_prdata = {16'h0000, cur_word};
      OFF_ERROR:      next_prdata = {24'h00_0000, error};
      OFF_STATUS:     next_prdata = {24'h00_0000, status};
      OFF_COMMAND:    next_prdata = 32'h0000_0000;
      OFF_DRIVE_HEAD: next_prdata = {24'h00_0000, drive_head};
      OFF_IRQ_STATUS: next_prdata = {29'h0000_0000, irq_status};
      OFF_IRQ_MASK:   next_prdata = {29'h0000_0000, irq_mask};
      default:        mapped      = 1'b0;
    endcase
  end

  // apb answer: one wait state, then pready with data and error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= (psel & penable & ~pready) ? next_prdata : 32'h0000_0000;
    end
  end

  // drive_select_head register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_head <= DRIVE_HEAD_RST;
    end else if (wr_take && paddr == OFF_DRIVE_HEAD) begin
      drive_head <= pwdata[7:0];
    end
  end

  // command engine: commands for another device or while busy are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      cmd_ok     <= 1'b0;
      word_index <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd_write && drive_head[DEV_BIT] == DEVICE_NUM) begin
            state  <= ST_PREPARE;
            cmd_ok <= (pwdata[7:0] == CMD_IDENTIFY);
          end
        end
        ST_PREPARE: begin
          state      <= cmd_ok ? ST_TRANSFER : ST_IDLE;
          word_index <= 8'h00;
        end
        ST_TRANSFER: begin
          if (data_pop) begin
            word_index <= word_index + 8'h01;
            if (word_index == LAST_WORD) begin
              state <= ST_IDLE;
            end
          end
        end
        // unused fourth code falls back to idle
        default: state <= ST_IDLE;
      endcase
    end
  end

  // status and error bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STATUS_RST;
      error  <= ERROR_RST;
    end else if (state == ST_IDLE && cmd_write && drive_head[DEV_BIT] == DEVICE_NUM) begin
      // command taken: busy, old outcome cleared
      status <= '{busy: 1'b1, default: 1'b0};
      error  <= ERROR_RST;
    end else if (ev_drq) begin
      status <= '{ready: 1'b1, seek_done: 1'b1, drq: 1'b1, default: 1'b0};
    end else if (ev_abort) begin
      status <= '{ready: 1'b1, seek_done: 1'b1, err: 1'b1, default: 1'b0};
      error  <= '{abort: 1'b1, default: 1'b0};
    end else if (ev_done) begin
      status <= '{ready: 1'b1, seek_done: 1'b1, default: 1'b0};
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= IRQ_RST;
    end else begin
      irq_status <= (irq_status & ~((wr_take && paddr == OFF_IRQ_STATUS) ? pwdata[2:0] : 3'h0))
                    | {ev_abort, ev_done, ev_drq};
    end
  end

  // interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= IRQ_RST;
    end else if (wr_take && paddr == OFF_IRQ_MASK) begin
      irq_mask <= pwdata[2:0];
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // helper: words handed out during the current transfer
  logic [8:0] reads_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reads_seen <= 9'h000;
    end else if (state == ST_PREPARE) begin
      reads_seen <= 9'h000;
    end else if (data_pop) begin
      reads_seen <= reads_seen + 9'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_identify_busy: assert property (
    state == ST_IDLE && cmd_write && drive_head[DEV_BIT] == DEVICE_NUM && pwdata[7:0] == CMD_IDENTIFY
    |=> status.busy ##1 (status.drq && !status.busy && state == ST_TRANSFER))
    else $error("identify command did not reach data request");

  a_sector_count: assert property (
    $fell(status.drq) |-> reads_seen == 9'(SECTOR_WORDS))
    else $error("transfer ended before a whole sector");

  a_drq_held: assert property (
    state == ST_TRANSFER && !ev_done |=> status.drq)
    else $error("data request dropped mid sector");

  a_word0_value: assert property (
    state == ST_TRANSFER && word_index == 8'h00 |-> cur_word == W0_COMPLETE || cur_word == W0_INCOMPLETE)
    else $error("word 0 has wrong classification");

  a_word6_value: assert property (
    state == ST_TRANSFER && word_index == 8'h06 |-> cur_word == W6_SECTORS)
    else $error("word 6 wrong");

  a_word47_value: assert property (
    state == ST_TRANSFER && word_index == 8'h2F |-> cur_word == W47_MULTIPLE)
    else $error("word 47 wrong");

  a_word48_value: assert property (
    state == ST_TRANSFER && word_index == 8'h30 |-> cur_word == W48_SECURITY)
    else $error("word 48 wrong");

  a_word3_upper: assert property (
    state == ST_TRANSFER && word_index == 8'h03 |-> cur_word[15:8] == 8'h00)
    else $error("word 3 upper byte not zero");

  // only abort bit may be set
  a_error_bits: assert property (
    error[7:3] == 5'h00 && error[1:0] == 2'h0)
    else $error("error bit other than abort set");

  a_done_status: assert property (
    ev_done |=> status.ready && !status.busy && !status.fault && !status.corrected && !status.err)
    else $error("completion status wrong");

  // abort reports error and no data
  a_abort_nodata: assert property (
    ev_abort |=> error.abort && status.err && !status.drq && state == ST_IDLE)
    else $error("abort not reported or data offered");

  // spin-up code follows the build options
  a_word2_value: assert property (
    state == ST_TRANSFER && word_index == 8'h02
    |-> cur_word == (SPINUP_NEEDED ? (INCOMPLETE ? W2_SPIN_PART : W2_SPIN_FULL)
                                   : (INCOMPLETE ? W2_NOSPIN_PART : W2_NOSPIN_FULL)))
    else $error("word 2 spin-up code wrong");

  a_reserved_zero: assert property (
    state == ST_TRANSFER && word_index inside {8'h04, 8'h05, 8'h07, 8'h08, 8'h09} |-> cur_word == WORD_ZERO)
    else $error("reserved geometry word not zero");

  a_word20_value: assert property (
    state == ST_TRANSFER && word_index == 8'h14 |-> cur_word == W20_CTRL_TYPE)
    else $error("word 20 wrong");

  a_word22_value: assert property (
    state == ST_TRANSFER && word_index == 8'h16 |-> cur_word == W22_ECC_BYTES)
    else $error("word 22 wrong");

  // each data read advances by one word
  a_index_order: assert property (
    data_pop |=> word_index == $past(word_index) + 8'h01)
    else $error("data words left out of order");

  // command for the other device ignored
  a_deselect_ignored: assert property (
    state == ST_IDLE && cmd_write && drive_head[DEV_BIT] != DEVICE_NUM |=> state == ST_IDLE && !status.busy)
    else $error("command for other device taken");

endmodule

// *** bench/host_model.sv ***
`timescale 1ns/1ps
// apb host: one transfer at a time, setup then access until pready
module host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  // bus idle from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until pready is sampled high
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines show no stale value
    pwrite  <= ~w;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// *** bench/identify_device_responder_bench.sv ***
`timescale 1ns/1ps
module identify_device_responder_bench;
  import identify_pkg::*;
  // one expected answer of the bus
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} note_type;
  localparam logic [15:0]  CYL  = 16'h1234;                   // cylinders
  localparam logic [7:0]   HDS  = 8'h0F;                      // heads
  localparam logic [15:0]  BUF  = 16'h0200;                   // buffer units
  localparam logic         SPIN = 1'b1;                       // spin-up needed
  localparam logic         INC  = 1'b0;                       // complete answer
  localparam logic [159:0] SER  = "SN0123456789ABCDEFGH";     // serial text
  localparam logic [63:0]  FW   = "FW012345";                 // firmware text
  localparam logic [319:0] MDL  = {"TEST MODEL", {30{8'h20}}}; // model text
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, code;
  logic [31:0] pwdata, prdata, last_rd, seed;
  note_type    notes[$];
  note_type    cur;
  int          errors, checked;

  identify_device_responder #(.CYLINDERS(CYL), .HEADS(HDS), .BUFFER_UNITS(BUF), .SPINUP_NEEDED(SPIN),
    .INCOMPLETE(INC), .DEVICE_NUM(1'b0), .SERIAL_TEXT(SER), .FIRMWARE_TEXT(FW), .MODEL_TEXT(MDL)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  host_model host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready));

  // free-running clock, 25 ns period
  always #12.5 pclk = ~pclk;

  // one comparison, counted
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  // watcher: each answer is matched against the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1 && notes.size() > 0) begin
      cur = notes.pop_front();
      chk("read data", cur.data & cur.mask, prdata & cur.mask);
      chk("slave error", {31'h0, cur.err}, {31'h0, pslverr});
    end
  end

  // note the expectation, then run the bus cycle
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                    input logic [31:0] m, input logic err);
    notes.push_back('{e, m, err});
    host_u.xfer(w, a, d, last_rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    op(1'b0, a, 32'h0000_0000, e, 32'hFFFF_FFFF, 1'b0);
  endtask

  // xorshift source of random codes
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    y = y ^ (y << 5);
    return y;
  endfunction

  // expected configuration word, first character in the upper byte
  function automatic logic [15:0] word_of(input int n);
    if (n == 0) return INC ? 16'h045E : 16'h045A;
    if (n == 1) return CYL;
    if (n == 2) return SPIN ? (INC ? 16'h37C8 : 16'h738C) : (INC ? 16'h8C73 : 16'hC837);
    if (n == 3) return {8'h00, HDS};
    if (n == 6) return 16'h003F;
    if (n >= 10 && n <= 19) return SER[159 - 16 * (n - 10) -: 16];
    if (n == 20) return 16'h0003;
    if (n == 21) return BUF;
    if (n == 22) return 16'h0038;
    if (n >= 23 && n <= 26) return FW[63 - 16 * (n - 23) -: 16];
    if (n >= 27 && n <= 46) return MDL[319 - 16 * (n - 27) -: 16];
    if (n == 47) return 16'h8010;
    if (n == 48) return 16'h4000;
    return 16'h0000;
  endfunction

  // full configuration command, sector read to the end
  task automatic identify();
    wr(OFF_IRQ_MASK, 32'h0000_0007);
    wr(OFF_COMMAND, {24'h0, CMD_IDENTIFY});
    do op(1'b0, OFF_STATUS, 32'h0, 32'h0, 32'h0, 1'b0); while (last_rd[3] !== 1'b1);
    rd(OFF_STATUS, 32'h0000_0058);
    rd(OFF_ERROR, 32'h0000_0000);
    chk("irq on drq", 32'h0000_0001, {31'h0, irq});
    rd(OFF_IRQ_STATUS, 32'h0000_0001);
    // the whole sector, words 0 to 22 first, then the rest
    for (int i = 0; i < 23; i++) begin
      rd(OFF_DATA, {16'h0, word_of(i)});
    end
    for (int i = 23; i < SECTOR_WORDS; i++) begin
      rd(OFF_DATA, {16'h0, word_of(i)});
    end
    rd(OFF_DATA, 32'h0000_0000);
    rd(OFF_STATUS, 32'h0000_0050);
    rd(OFF_IRQ_STATUS, 32'h0000_0003);
    wr(OFF_IRQ_STATUS, 32'h0000_0007);
    rd(OFF_IRQ_STATUS, 32'h0000_0000);
  endtask

  // print counts and verdict, end the run
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog far beyond the expected run time
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    stop_test();
  end

  // main sequence
  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    errors  = 0;
    checked = 0;
    seed    = 32'hbc4b_656f;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_STATUS, 32'h0000_0050);
    rd(OFF_ERROR, 32'h0000_0000);
    rd(OFF_DRIVE_HEAD, 32'h0000_00A0);
    rd(OFF_IRQ_STATUS, 32'h0000_0000);
    rd(OFF_IRQ_MASK, 32'h0000_0000);
    rd(OFF_COMMAND, 32'h0000_0000);
    rd(OFF_DATA, 32'h0000_0000);
    op(1'b0, 8'h1C, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
    op(1'b1, 8'h1C, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b1);
    $display("test reset done");
    identify();
    $display("test identify done");
    // other device selected: command ignored
    wr(OFF_DRIVE_HEAD, 32'h0000_00B0);
    wr(OFF_COMMAND, {24'h0, CMD_IDENTIFY});
    rd(OFF_STATUS, 32'h0000_0050);
    rd(OFF_DATA, 32'h0000_0000);
    wr(OFF_DRIVE_HEAD, 32'h0000_00A0);
    $display("test deselect done");
    // reset in mid-sector drops the transfer and every register
    wr(OFF_COMMAND, {24'h0, CMD_IDENTIFY});
    do op(1'b0, OFF_STATUS, 32'h0, 32'h0, 32'h0, 1'b0); while (last_rd[3] !== 1'b1);
    for (int i = 0; i < 12; i++) begin
      rd(OFF_DATA, {16'h0, word_of(i)});
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_STATUS, 32'h0000_0050);
    rd(OFF_DATA, 32'h0000_0000);
    rd(OFF_IRQ_STATUS, 32'h0000_0000);
    rd(OFF_IRQ_MASK, 32'h0000_0000);
    wr(OFF_IRQ_MASK, 32'h0000_0007);
    $display("test reset mid-sector done");
    // random non-identify codes are aborted
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      code = (seed[7:0] == CMD_IDENTIFY) ? 8'h00 : seed[7:0];
      wr(OFF_COMMAND, {24'h0, code});
      rd(OFF_STATUS, 32'h0000_0051);
      rd(OFF_ERROR, 32'h0000_0004);
      rd(OFF_DATA, 32'h0000_0000);
      chk("irq on abort", 32'h0000_0001, {31'h0, irq});
      wr(OFF_IRQ_MASK, 32'h0000_0000);
      rd(OFF_IRQ_STATUS, 32'h0000_0004);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      wr(OFF_IRQ_STATUS, 32'h0000_0004);
      wr(OFF_IRQ_MASK, 32'h0000_0007);
    end
    $display("test abort done");
    identify();
    $display("test second identify done");
    stop_test();
  end
endmodule
